// file: src/adcsf_pkg.sv
// Constants and types shared by the converter serial frame controller.
`default_nettype none
package adcsf_pkg;
   // ************************************************************
   // Word layout.
   // ************************************************************
   localparam int ADCSF_DATA_W = 12;
   localparam int ADCSF_WORD_W = 16;
   localparam int ADCSF_CNT_W = 5;
   localparam logic [2:0] ADCSF_LEAD_ZEROS = 3'h0;
   localparam logic ADCSF_PAD_BIT = 1'h0;
   // ************************************************************
   // Serial clock falling-edge milestones within a frame.
   // ************************************************************
   localparam logic [ADCSF_CNT_W-1:0] ADCSF_GLITCH_EDGE = 5'h02;
   localparam logic [ADCSF_CNT_W-1:0] ADCSF_MODE_EDGE = 5'h0A;
   localparam logic [ADCSF_CNT_W-1:0] ADCSF_TRACK_EDGE = 5'h0C;
   localparam logic [ADCSF_CNT_W-1:0] ADCSF_LAST_SHIFT = 5'h0F;
   localparam logic [ADCSF_CNT_W-1:0] ADCSF_LAST_EDGE = 5'h10;
   // ************************************************************
   // Reset values.
   // ************************************************************
   localparam logic [ADCSF_CNT_W-1:0] ADCSF_CNT_RST = 5'h00;
   localparam logic ADCSF_PIN_HIGH_RST = 1'h1;
   localparam logic ADCSF_PIN_LOW_RST = 1'h0;
   localparam logic ADCSF_FLAG_RST = 1'h0;
   localparam logic [ADCSF_WORD_W-1:0] ADCSF_WORD_RST = 16'h0000;
   // ************************************************************
   // Host-side timing, kept for the bench and for reference.
   // ************************************************************
   localparam int ADCSF_CLK_PERIOD_NS = 50;
   localparam int ADCSF_INTER_FRAME_GAP_NS = 50;
   localparam int ADCSF_TRACK_INTERVAL_NS = 350;
   localparam int ADCSF_INTER_FRAME_GAP_CYC =
      (ADCSF_INTER_FRAME_GAP_NS + ADCSF_CLK_PERIOD_NS - 1) / ADCSF_CLK_PERIOD_NS;
   localparam int ADCSF_TRACK_INTERVAL_CYC =
      (ADCSF_TRACK_INTERVAL_NS + ADCSF_CLK_PERIOD_NS - 1) / ADCSF_CLK_PERIOD_NS;
   // ************************************************************
   // Power modes.
   // ************************************************************
   typedef enum logic [1:0] {
      ADCSF_MODE_NORMAL = 2'b00,
      ADCSF_MODE_SHUTDOWN = 2'b01,
      ADCSF_MODE_WAKING = 2'b10
   } adcsf_mode_t;
endpackage
`default_nettype wire

// file: src/adcsf_shift_if.sv
// Carrier between the frame controller and its result shifter.
`default_nettype none
interface adcsf_shift_if;
   import adcsf_pkg::*;
   logic load;
   logic shift;
   logic drop;
   logic [ADCSF_WORD_W-1:0] word;
   logic bit_out;
   logic oe;
   modport ctrl (output load, output shift, output drop, output word, input bit_out, input oe);
   modport shifter (input load, input shift, input drop, input word, output bit_out, output oe);
endinterface
`default_nettype wire

// file: src/adcsf_shifter.sv
// Result shift register with its output enable.
`default_nettype none
module adcsf_shifter
   import adcsf_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   adcsf_shift_if.shifter sh
);
   logic [ADCSF_WORD_W-1:0] word_ff;
   logic oe_ff;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         word_ff <= ADCSF_WORD_RST;
      end else if (sh.load) begin
         word_ff <= sh.word;
      end else if (sh.shift) begin
         word_ff <= {word_ff[ADCSF_WORD_W-2:0], ADCSF_PAD_BIT};
      end
   end

   // A drop outranks a load so a frame that ends and restarts in one cycle stays quiet.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         oe_ff <= ADCSF_FLAG_RST;
      end else if (sh.drop) begin
         oe_ff <= 1'b0;
      end else if (sh.load) begin
         oe_ff <= 1'b1;
      end
   end

   assign sh.bit_out = word_ff[ADCSF_WORD_W-1];
   assign sh.oe = oe_ff;
endmodule
`default_nettype wire

// file: src/adcsf_top.sv
// Serial result frame and power mode controller of the converter.
// Contract
// - Frame select falling enters normal mode (waking if in shutdown) and restarts the edge count.
// - Rise between second and tenth falling edge aborts, floats output, enters shutdown.
// - Rise before the second falling edge leaves normal mode unchanged.
// - Rise after tenth, before sixteenth edge: stay normal, abort, float output.
// - Shutdown holds until frame select goes low again.
// - After the sixteenth falling edge the output floats even with select low.
// - Select low in shutdown starts power-up; that first result is a dummy.
// - Wake frame ended before the tenth falling edge returns to shutdown.
// - Wake frame held past tenth edge is powered up after sixteen clocks.
// - Word is three zeros then twelve data bits, most significant first.
// - Bits change on serial clock falling edges; host samples on rising edges.
`default_nettype none
module adcsf_top
   import adcsf_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic frame_sel_n,
   input wire logic ser_clk,
   input wire logic [ADCSF_DATA_W-1:0] conv_word,
   output logic serial_result_out,
   output logic serial_result_oe,
   output logic shutdown_mode,
   output logic track_mode,
   output logic powered_up,
   output logic result_dummy
);
   // ************************************************************
   // Pin synchronisers and edge detection.
   // ************************************************************
   logic sel_meta_ff, sel_sync_ff, sel_prev_ff;
   logic sck_meta_ff, sck_sync_ff, sck_prev_ff;
   logic sel_fall, sel_rise, sck_fall, sck_rise;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sel_meta_ff <= ADCSF_PIN_HIGH_RST;
         sel_sync_ff <= ADCSF_PIN_HIGH_RST;
         sel_prev_ff <= ADCSF_PIN_HIGH_RST;
      end else begin
         sel_meta_ff <= frame_sel_n;
         sel_sync_ff <= sel_meta_ff;
         sel_prev_ff <= sel_sync_ff;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sck_meta_ff <= ADCSF_PIN_LOW_RST;
         sck_sync_ff <= ADCSF_PIN_LOW_RST;
         sck_prev_ff <= ADCSF_PIN_LOW_RST;
      end else begin
         sck_meta_ff <= ser_clk;
         sck_sync_ff <= sck_meta_ff;
         sck_prev_ff <= sck_sync_ff;
      end
   end

   assign sel_fall = sel_prev_ff & ~sel_sync_ff;
   assign sel_rise = ~sel_prev_ff & sel_sync_ff;
   assign sck_fall = sck_prev_ff & ~sck_sync_ff;
   assign sck_rise = ~sck_prev_ff & sck_sync_ff;

   // ************************************************************
   // Frame tracking and falling-edge count.
   // ************************************************************
   logic frame_ff;
   logic [ADCSF_CNT_W-1:0] fall_cnt_ff;
   logic frame_fall;
   adcsf_mode_t mode_ff;

   // Edges seen while select is high never count.
   assign frame_fall = frame_ff & sck_fall & ~sel_rise;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         frame_ff <= ADCSF_FLAG_RST;
      end else if (sel_fall) begin
         frame_ff <= 1'b1;
      end else if (sel_rise) begin
         frame_ff <= 1'b0;
      end
   end

   // The count saturates so a select held low after the word cannot wrap it.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         fall_cnt_ff <= ADCSF_CNT_RST;
      end else if (sel_fall || sel_rise) begin
         fall_cnt_ff <= ADCSF_CNT_RST;
      end else if (frame_fall && fall_cnt_ff != ADCSF_LAST_EDGE) begin
         fall_cnt_ff <= fall_cnt_ff + 5'h01;
      end
   end

   function automatic logic in_shutdown_band(input logic [ADCSF_CNT_W-1:0] cnt);
      in_shutdown_band = (cnt >= ADCSF_GLITCH_EDGE) && (cnt < ADCSF_MODE_EDGE);
   endfunction

   // ************************************************************
   // Power mode.
   // ************************************************************
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mode_ff <= ADCSF_MODE_NORMAL;
      end else if (sel_fall) begin
         if (mode_ff == ADCSF_MODE_SHUTDOWN) begin
            mode_ff <= ADCSF_MODE_WAKING;
         end else begin
            mode_ff <= ADCSF_MODE_NORMAL;
         end
      end else if (sel_rise && frame_ff) begin
         unique case (mode_ff)
            ADCSF_MODE_NORMAL: begin
               if (in_shutdown_band(fall_cnt_ff)) begin
                  mode_ff <= ADCSF_MODE_SHUTDOWN;
               end
            end
            ADCSF_MODE_WAKING: begin
               if (fall_cnt_ff < ADCSF_MODE_EDGE) begin
                  mode_ff <= ADCSF_MODE_SHUTDOWN;
               end else begin
                  mode_ff <= ADCSF_MODE_NORMAL;
               end
            end
            ADCSF_MODE_SHUTDOWN: begin
               mode_ff <= ADCSF_MODE_SHUTDOWN;
            end
            default: begin
               mode_ff <= ADCSF_MODE_NORMAL;
            end
         endcase
      end else if (frame_fall && fall_cnt_ff == ADCSF_LAST_SHIFT && mode_ff == ADCSF_MODE_WAKING) begin
         mode_ff <= ADCSF_MODE_NORMAL;
      end
   end

   // Power is lost in shutdown; it returns only at the end of a full frame.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         powered_up <= ADCSF_FLAG_RST;
      end else if (mode_ff == ADCSF_MODE_SHUTDOWN) begin
         powered_up <= 1'b0;
      end else if (frame_fall && fall_cnt_ff == ADCSF_LAST_SHIFT) begin
         powered_up <= 1'b1;
      end
   end

   // The first frame after reset or wake-up converts while still powering up.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         result_dummy <= ADCSF_FLAG_RST;
      end else if (sel_fall) begin
         result_dummy <= ~powered_up | (mode_ff == ADCSF_MODE_SHUTDOWN);
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         shutdown_mode <= ADCSF_FLAG_RST;
      end else begin
         shutdown_mode <= (mode_ff == ADCSF_MODE_SHUTDOWN);
      end
   end

   // The sampler returns to tracking on the thirteenth rising edge.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         track_mode <= ADCSF_PIN_HIGH_RST;
      end else if (sel_fall) begin
         track_mode <= 1'b0;
      end else if (frame_ff && sck_rise && fall_cnt_ff == ADCSF_TRACK_EDGE) begin
         track_mode <= 1'b1;
      end else if (sel_rise) begin
         track_mode <= 1'b1;
      end
   end

   // ************************************************************
   // Result shifter.
   // ************************************************************
   adcsf_shift_if sh_if ();

   assign sh_if.load = sel_fall;
   assign sh_if.word = {ADCSF_LEAD_ZEROS, conv_word, ADCSF_PAD_BIT};
   assign sh_if.shift = frame_fall && (fall_cnt_ff < ADCSF_LAST_SHIFT);
   assign sh_if.drop = sel_rise || (frame_fall && fall_cnt_ff == ADCSF_LAST_SHIFT);

   adcsf_shifter u_shifter (
      .clock(clock),
      .reset_n(reset_n),
      .sh(sh_if.shifter)
   );

   assign serial_result_out = sh_if.bit_out;
   assign serial_result_oe = sh_if.oe;

   // ************************************************************
   // Checks.
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   property p_start_normal;
      sel_fall |=> frame_ff && fall_cnt_ff == 5'h00 && mode_ff != ADCSF_MODE_SHUTDOWN ##1 serial_result_oe;
   endproperty
   a_start_normal: assert property (p_start_normal) else $error("frame start not taken");

   property p_enter_shutdown;
      sel_rise && frame_ff && mode_ff == ADCSF_MODE_NORMAL && in_shutdown_band(fall_cnt_ff)
         |=> mode_ff == ADCSF_MODE_SHUTDOWN && !serial_result_oe ##1 shutdown_mode;
   endproperty
   a_enter_shutdown: assert property (p_enter_shutdown) else $error("shutdown not entered");

   property p_glitch_keep;
      sel_rise && frame_ff && mode_ff == ADCSF_MODE_NORMAL && fall_cnt_ff < 5'h02 |=> mode_ff == ADCSF_MODE_NORMAL;
   endproperty
   a_glitch_keep: assert property (p_glitch_keep) else $error("mode changed on short frame");

   property p_late_abort;
      sel_rise && frame_ff && mode_ff == ADCSF_MODE_NORMAL && fall_cnt_ff >= 5'h0A && fall_cnt_ff < 5'h10
         |=> mode_ff == ADCSF_MODE_NORMAL && !serial_result_oe;
   endproperty
   a_late_abort: assert property (p_late_abort) else $error("late abort wrong");

   property p_hold_shutdown;
      mode_ff == ADCSF_MODE_SHUTDOWN && !sel_fall |=> mode_ff == ADCSF_MODE_SHUTDOWN;
   endproperty
   a_hold_shutdown: assert property (p_hold_shutdown) else $error("shutdown left without select");

   property p_float_after_last;
      frame_fall && fall_cnt_ff == 5'h0F |=> !serial_result_oe && fall_cnt_ff == 5'h10 ##1 !serial_result_oe;
   endproperty
   a_float_after_last: assert property (p_float_after_last) else $error("output driven after word");

   property p_wake_dummy;
      sel_fall && mode_ff == ADCSF_MODE_SHUTDOWN |=> result_dummy && mode_ff == ADCSF_MODE_WAKING;
   endproperty
   a_wake_dummy: assert property (p_wake_dummy) else $error("wake frame not marked dummy");

   property p_wake_abort;
      sel_rise && frame_ff && mode_ff == ADCSF_MODE_WAKING && fall_cnt_ff < 5'h0A
         |=> mode_ff == ADCSF_MODE_SHUTDOWN ##1 shutdown_mode && !powered_up;
   endproperty
   a_wake_abort: assert property (p_wake_abort) else $error("wake abort not back to shutdown");

   property p_powered;
      frame_fall && fall_cnt_ff == 5'h0F && mode_ff == ADCSF_MODE_WAKING |=> powered_up && mode_ff == ADCSF_MODE_NORMAL;
   endproperty
   a_powered: assert property (p_powered) else $error("not powered after full wake frame");

   property p_lead_zero;
      sel_fall |=> !serial_result_out ##0 sh_if.oe;
   endproperty
   a_lead_zero: assert property (p_lead_zero) else $error("first bit not zero");

   property p_float_idle;
      sel_sync_ff && sel_prev_ff |=> !serial_result_oe && fall_cnt_ff == 5'h00;
   endproperty
   a_float_idle: assert property (p_float_idle) else $error("output or count live while idle");

   property p_ignore_idle_clock;
      !frame_ff && !sel_fall |=> $stable(fall_cnt_ff) && $stable(mode_ff);
   endproperty
   a_ignore_idle_clock: assert property (p_ignore_idle_clock) else $error("idle clock changed state");

   c_full_frame: cover property (frame_fall && fall_cnt_ff == 5'h0F);
   c_shutdown: cover property (sel_rise && mode_ff == ADCSF_MODE_NORMAL && in_shutdown_band(fall_cnt_ff));
   c_wake_done: cover property (mode_ff == ADCSF_MODE_WAKING ##1 mode_ff == ADCSF_MODE_NORMAL);
endmodule
`default_nettype wire

// file: verification/adcsf_host.sv
// Host serial controller model that frames conversions and captures result bits.
`default_nettype none
module adcsf_host (
   input wire logic clock,
   input wire logic serial_result_out,
   input wire logic serial_result_oe,
   output logic frame_sel_n,
   output logic ser_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rx_word;
   logic oe_all;
   logic last_bit;
   logic line_lvl;
   // A released line shows the inverse of its last driven bit, so stale data never passes as good.
   assign line_lvl = serial_result_oe ? serial_result_out : ~last_bit;
   always @(posedge clock) begin
      if (serial_result_oe) begin
         last_bit <= serial_result_out;
      end
   end
   initial begin
      frame_sel_n = 1'b1;
      ser_clk = 1'b0;
      rx_word = 16'h0000;
      oe_all = 1'b1;
      last_bit = 1'b0;
   end
   // ************************************************************
   // One frame: select low, a number of serial clock cycles, optional release.
   // ************************************************************
   task automatic frame(input int falls, input bit hold_low);
      rx_word = 16'h0000;
      oe_all = 1'b1;
      @(posedge clock);
      frame_sel_n <= 1'b0;
      repeat (4) @(posedge clock);
      // The clock idles low, so each cycle is a rise that takes the standing bit, then a fall that moves the next.
      for (int i = 0; i < falls; i++) begin
         @(negedge clock);
         rx_word = {rx_word[14:0], line_lvl};
         oe_all = oe_all & serial_result_oe;
         @(posedge clock);
         ser_clk <= 1'b1;
         repeat (4) @(posedge clock);
         ser_clk <= 1'b0;
         repeat (3) @(posedge clock);
      end
      repeat (4) @(posedge clock);
      if (!hold_low) begin
         frame_sel_n <= 1'b1;
      end
      // The idle wait covers the gap and the track interval before any next frame.
      repeat (10) @(posedge clock);
   endtask
   // Releases a select that a frame left low.
   task automatic end_frame();
      @(posedge clock);
      frame_sel_n <= 1'b1;
      repeat (10) @(posedge clock);
   endtask
   // Serial clock cycles with select high, which the device must ignore.
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         ser_clk <= 1'b1;
         repeat (4) @(posedge clock);
         ser_clk <= 1'b0;
         repeat (4) @(posedge clock);
      end
   endtask
endmodule
`default_nettype wire

// file: verification/adcsf_top_tb.sv
// Self-checking bench for the converter serial frame and power mode controller.
`default_nettype none
module adcsf_top_tb;
   import adcsf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock;
   logic reset_n;
   logic frame_sel_n;
   logic ser_clk;
   logic [ADCSF_DATA_W-1:0] conv_word;
   logic serial_result_out;
   logic serial_result_oe;
   logic shutdown_mode;
   logic track_mode;
   logic powered_up;
   logic result_dummy;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   adcsf_top dut (.clock(clock), .reset_n(reset_n), .frame_sel_n(frame_sel_n), .ser_clk(ser_clk),
      .conv_word(conv_word), .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
      .shutdown_mode(shutdown_mode), .track_mode(track_mode), .powered_up(powered_up),
      .result_dummy(result_dummy));
   adcsf_host u_host (.clock(clock), .serial_result_out(serial_result_out),
      .serial_result_oe(serial_result_oe), .frame_sel_n(frame_sel_n), .ser_clk(ser_clk));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // ************************************************************
   // Shared checking and closing.
   // ************************************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic set_conv(input logic [11:0] v);
      @(posedge clock);
      conv_word <= v;
   endtask
   // ************************************************************
   // Scenarios.
   // ************************************************************
   task automatic sc_reset();
      check("oe", {15'h0, serial_result_oe}, 16'h0000);
      check("shutdown", {15'h0, shutdown_mode}, 16'h0000);
      check("track", {15'h0, track_mode}, 16'h0001);
      check("powered", {15'h0, powered_up}, 16'h0000);
   endtask
   task automatic sc_first_frame();
      set_conv(12'hA5C);
      u_host.frame(16, 1'b1);
      check("oe after 16", {15'h0, serial_result_oe}, 16'h0000);
      check("oe in frame", {15'h0, u_host.oe_all}, 16'h0001);
      check("word", u_host.rx_word, {3'h0, 12'hA5C, 1'b0});
      check("dummy first", {15'h0, result_dummy}, 16'h0001);
      check("powered", {15'h0, powered_up}, 16'h0001);
      check("track after 13", {15'h0, track_mode}, 16'h0001);
      u_host.end_frame();
      check("shutdown", {15'h0, shutdown_mode}, 16'h0000);
   endtask
   task automatic sc_valid_frame();
      set_conv(12'h3C9);
      u_host.frame(16, 1'b0);
      check("word", u_host.rx_word, {3'h0, 12'h3C9, 1'b0});
      check("dummy second", {15'h0, result_dummy}, 16'h0000);
      check("track", {15'h0, track_mode}, 16'h0001);
   endtask
   task automatic sc_glitch();
      u_host.frame(1, 1'b0);
      check("shutdown glitch", {15'h0, shutdown_mode}, 16'h0000);
      check("oe idle", {15'h0, serial_result_oe}, 16'h0000);
   endtask
   task automatic sc_keep_normal();
      set_conv(12'h6B1);
      u_host.frame(10, 1'b1);
      check("track in hold", {15'h0, track_mode}, 16'h0000);
      check("oe before abort", {15'h0, serial_result_oe}, 16'h0001);
      u_host.end_frame();
      check("shutdown at 10", {15'h0, shutdown_mode}, 16'h0000);
      check("oe abort", {15'h0, serial_result_oe}, 16'h0000);
      check("partial", u_host.rx_word, {6'h00, 3'h0, 7'h35});
   endtask
   task automatic sc_enter_shutdown();
      u_host.frame(2, 1'b0);
      check("shutdown at 2", {15'h0, shutdown_mode}, 16'h0001);
      check("oe", {15'h0, serial_result_oe}, 16'h0000);
      check("powered", {15'h0, powered_up}, 16'h0000);
      u_host.idle_clocks(4);
      check("shutdown held", {15'h0, shutdown_mode}, 16'h0001);
   endtask
   task automatic sc_wake_abort();
      u_host.frame(9, 1'b0);
      check("wake abort", {15'h0, shutdown_mode}, 16'h0001);
   endtask
   task automatic sc_wake_full();
      set_conv(12'h5A3);
      u_host.frame(16, 1'b0);
      check("woken", {15'h0, shutdown_mode}, 16'h0000);
      check("dummy wake", {15'h0, result_dummy}, 16'h0001);
      check("powered", {15'h0, powered_up}, 16'h0001);
      set_conv(12'h0F0);
      u_host.frame(16, 1'b0);
      check("dummy next", {15'h0, result_dummy}, 16'h0000);
      check("word", u_host.rx_word, {3'h0, 12'h0F0, 1'b0});
   endtask
   initial begin
      reset_n = 1'b0;
      conv_word = 12'h000;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      sc_reset();
      sc_first_frame();
      sc_valid_frame();
      sc_glitch();
      sc_keep_normal();
      sc_enter_shutdown();
      sc_wake_abort();
      sc_wake_full();
      complete_run();
   end
endmodule
`default_nettype wire
